// ### verilog/epb_pkg.sv
package epb_pkg;
   localparam int AW = 32;
   localparam int DW = 32;
   localparam int WFIFO_DEPTH = 4;
   localparam int NBR_DEPTH = 16;
   // Configuration port selects
   localparam logic [3:0] SEL_CFG = 4'h0;
   localparam logic [3:0] SEL_CSPROT = 4'h1;
   localparam logic [3:0] SEL_ADDRMAP = 4'h2;
   localparam logic [3:0] SEL_GPCFG = 4'h3;
   localparam logic [3:0] SEL_BAUD = 4'h4;
   localparam logic [3:0] SEL_RDCTL0 = 4'h5;
   localparam logic [3:0] SEL_RDADDR0 = 4'h6;
   localparam logic [3:0] SEL_RDSIZE0 = 4'h7;
   localparam logic [3:0] SEL_IMASK = 4'hb;
   localparam logic [3:0] SEL_ICLR = 4'hc;
   localparam logic [3:0] SEL_RTWIN = 4'hd;
   localparam logic [3:0] SEL_SET_STRIDE = 4'h3;
   // Modes
   localparam logic [1:0] MODE_GP = 2'h0;
   localparam logic [1:0] MODE_SDRAM = 2'h1;
   localparam logic [1:0] MODE_HB8 = 2'h2;
   localparam logic [1:0] MODE_HB16 = 2'h3;
   // Field positions
   localparam int GP_FRAME_EN = 5;
   localparam int GP_CLK_GATED = 6;
   localparam int RTWIN_EN = 0;
   localparam int RTWIN_LEN_LSB = 8;
   localparam int IRQ_DONE0 = 0;
   localparam int IRQ_NBR = 2;
   localparam int IRQ_WSPACE = 3;
   // Reset values and limits
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic [7:0] CSPROT_RST = 8'hff;
   localparam logic [4:0] FRAME_MIN = 5'h01;
   localparam logic [4:0] FRAME_MAX = 5'h1e;
   localparam logic [15:0] BAUD_RST = 16'h0001;
   localparam logic [3:0] IMASK_RST = 4'h0;
   // Cycle counts and word address step
   localparam logic [1:0] STROBE_LAST = 2'h1;
   localparam logic [1:0] BRIDGE_HALF = 2'h1;
   localparam logic [1:0] BRIDGE_QUARTER = 2'h3;
   localparam logic [31:0] WORD_STEP = 32'h0000_0004;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WR = 2'b01,
      ST_RD = 2'b10,
      ST_NB = 2'b11
   } epb_state_e;
endpackage : epb_pkg

// ### verilog/epb_fifo.sv
`timescale 1ns/100ps
module epb_fifo
   #(parameter int WIDTH = 32,
     parameter int DEPTH = 16)
   (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
   );
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wp;
   logic [PW-1:0] rp;
   logic [PW:0] cnt;
   logic push;
   logic pop;

   assign in_ready = (cnt != DEPTH[PW:0]);
   assign out_valid = (cnt != '0);
   assign out_data = mem[rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge core_clk)
   begin
      if (push)
      begin
         mem[wp] <= in_data;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
      end
      else
      begin
         if (push)
         begin
            wp <= (wp == PW'(DEPTH - 1)) ? '0 : wp + 1'b1;
         end
         if (pop)
         begin
            rp <= (rp == PW'(DEPTH - 1)) ? '0 : rp + 1'b1;
         end
         cnt <= cnt + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule : epb_fifo

// ### verilog/epb_core.sv
`timescale 1ns/100ps
// Contract
// - Four-word write buffer; stall only when full
// - Zero read-data control means blocking read
// - Nonzero read-data write starts background reads when the set's size is nonzero
// - Background data buffered, interrupt raised
// - Two read sets ping-pong into buffer
// - Transfers routed by configured mode
// - Mode value zero selects general-purpose
// - Modes: general, SDRAM, host 8/16
// - Master priority or control-owned window
// - Chip-select ownership blocks foreign transfers
// - Control writes only window registers
// - Control path runs at half/quarter rate
// - Interrupt to DMA 20/22, both CPUs
// - Four interrupt registers: raw, mask, clear, masked
// - Address passes or remaps via MSB
// - Frame output, length 1 to 30
// - External clock from baud divider
// - External clock gated or free-running
// - Revision zero: control has no access
module epb_core
   import epb_pkg::*;
   (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic strap_rev0,
   input wire logic ctl_bridge_quarter,
   input wire logic m_req,
   input wire logic m_we,
   input wire logic [AW-1:0] m_addr,
   input wire logic [DW-1:0] m_wdata,
   output logic m_ready,
   output logic m_err,
   input wire logic c_req,
   input wire logic c_we,
   input wire logic [AW-1:0] c_addr,
   input wire logic [DW-1:0] c_wdata,
   output logic c_ready,
   output logic c_err,
   output logic [DW-1:0] resp_rdata,
   input wire logic cfg_wr,
   input wire logic cfg_from_ctl,
   input wire logic [3:0] cfg_sel,
   input wire logic [DW-1:0] cfg_wdata,
   output logic [3:0] irq_raw,
   output logic [3:0] irq_masked,
   output logic irq_m_cpu,
   output logic irq_c_cpu,
   output logic dma_req_ch20,
   output logic dma_req_ch22,
   output logic nbr_valid,
   input wire logic nbr_ready,
   output logic [DW-1:0] nbr_data,
   output logic ext_clk,
   output logic ext_frame,
   output logic ext_rd,
   output logic ext_wr,
   output logic [AW-1:0] ext_addr,
   output logic [DW-1:0] ext_data_o,
   output logic ext_data_oe_n,
   input wire logic [DW-1:0] ext_data_i,
   output logic sdram_req,
   output logic host_req,
   output logic alt_we,
   output logic [AW-1:0] alt_addr,
   output logic [DW-1:0] alt_wdata,
   input wire logic alt_done,
   input wire logic [DW-1:0] alt_rdata
   );
   epb_state_e state;
   logic rev0;
   logic [1:0] mode;
   logic [7:0] csprot;
   logic [4:0] addrmap;
   logic [6:0] gpcfg;
   logic [15:0] baud;
   logic [3:0] imask;
   logic [15:0] rtwin;
   logic cfg_ok;
   logic [DW-1:0] rd_ctl [2];
   logic [AW-1:0] rd_addr [2];
   logic [15:0] rd_size [2];
   logic [15:0] rd_left [2];
   logic [1:0] nb_act;
   logic [1:0] set_fin;
   logic cur_set;
   logic [1:0] br_cnt;
   logic c_slot;
   logic [7:0] win_cnt;
   logic win_active;
   logic pick_m;
   logic pick_c;
   logic sel_we;
   logic [AW-1:0] sel_addr;
   logic own_ok;
   logic take;
   logic rd_pend;
   logic rd_owner_c;
   logic [AW-1:0] rd_paddr;
   logic rd_fin;
   logic wf_in_ready;
   logic wf_out_valid;
   logic [AW+DW-1:0] wf_out;
   logic nbr_in_ready;
   logic j_alt;
   logic j_we;
   logic [AW-1:0] j_addr;
   logic launch;
   logic job_done;
   logic gp_done;
   logic [DW-1:0] j_rdata;
   logic [15:0] baud_cnt;
   logic tick;
   logic [1:0] ph;
   logic [4:0] frame_cnt;
   logic [DW-1:0] din_s1;
   logic [DW-1:0] din_s2;
   logic [DW-1:0] din_s3;
   logic din_stable;
   logic [1:0] done_stk;

   function automatic logic [AW-1:0] remap(input logic [AW-1:0] a, input logic [4:0] map);
      remap = (map[0] && a[AW-1]) ? {map[4:1], a[AW-5:0]} : a;
   endfunction : remap

   ////////////////////////////////////////////////////////////////////////////
   // Configuration
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         rev0 <= strap_rev0;
      end
   end

   assign cfg_ok = cfg_wr && (!cfg_from_ctl || (cfg_sel == SEL_RTWIN && !rev0));

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         mode <= MODE_RST;
         csprot <= CSPROT_RST;
         addrmap <= '0;
         gpcfg <= {2'b00, FRAME_MIN};
         baud <= BAUD_RST;
         imask <= IMASK_RST;
         rtwin <= '0;
      end
      else if (cfg_ok)
      begin
         unique case (cfg_sel)
            SEL_CFG: mode <= cfg_wdata[1:0];
            SEL_CSPROT: csprot <= cfg_wdata[7:0];
            SEL_ADDRMAP: addrmap <= cfg_wdata[4:0];
            SEL_GPCFG:
            begin
               gpcfg[6:5] <= cfg_wdata[6:5];
               gpcfg[4:0] <= (cfg_wdata[4:0] < FRAME_MIN) ? FRAME_MIN :
                  (cfg_wdata[4:0] > FRAME_MAX) ? FRAME_MAX : cfg_wdata[4:0];
            end
            SEL_BAUD: baud <= cfg_wdata[15:0];
            SEL_IMASK: imask <= cfg_wdata[3:0];
            SEL_RTWIN: rtwin <= cfg_wdata[15:0];
            default:;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Front end: bridge rate, arbitration, chip-select protection
   assign c_slot = (br_cnt == (ctl_bridge_quarter ? BRIDGE_QUARTER : BRIDGE_HALF));

   always_ff @(posedge core_clk)
   begin
      if (srst || c_slot)
      begin
         br_cnt <= '0;
      end
      else
      begin
         br_cnt <= br_cnt + 2'h1;
      end
   end

   assign win_active = (win_cnt != '0);
   assign pick_m = m_req && !win_active;
   assign pick_c = c_req && c_slot && !rev0 && !pick_m;
   assign sel_we = pick_m ? m_we : c_we;
   assign sel_addr = pick_m ? m_addr : c_addr;
   assign own_ok = csprot[{sel_addr[29:28], pick_c}];
   assign take = (pick_m || pick_c) && (!own_ok || (sel_we ? wf_in_ready : !rd_pend));

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         win_cnt <= '0;
      end
      else if (take && pick_c && rtwin[RTWIN_EN])
      begin
         win_cnt <= rtwin[RTWIN_LEN_LSB +: 8];
      end
      else if (win_active)
      begin
         win_cnt <= win_cnt - 8'h01;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         m_err <= 1'b0;
         c_err <= 1'b0;
      end
      else
      begin
         m_err <= take && pick_m && !own_ok;
         c_err <= take && pick_c && !own_ok;
      end
   end

   assign m_ready = (take && pick_m && (sel_we || !own_ok)) || (rd_fin && !rd_owner_c);
   assign c_ready = (take && pick_c && (sel_we || !own_ok)) || (rd_fin && rd_owner_c);

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         rd_pend <= 1'b0;
         rd_owner_c <= 1'b0;
         rd_paddr <= '0;
         rd_fin <= 1'b0;
      end
      else
      begin
         rd_fin <= job_done && state == ST_RD;
         if (take && own_ok && !sel_we)
         begin
            rd_pend <= 1'b1;
            rd_owner_c <= pick_c;
            rd_paddr <= remap(sel_addr, addrmap);
         end
         else if (rd_fin)
         begin
            rd_pend <= 1'b0;
         end
      end
   end

   epb_fifo #(.WIDTH(AW + DW), .DEPTH(WFIFO_DEPTH)) wfifo_i (
      .core_clk(core_clk),
      .srst(srst),
      .in_valid(take && own_ok && sel_we),
      .in_ready(wf_in_ready),
      .in_data({remap(sel_addr, addrmap), pick_m ? m_wdata : c_wdata}),
      .out_valid(wf_out_valid),
      .out_ready(launch && wf_out_valid),
      .out_data(wf_out)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Background read sets
   generate
      for (genvar s = 0; s < 2; s++)
      begin : g_set
         logic [3:0] base;
         logic step;
         assign base = SEL_RDCTL0 + 4'(s) * SEL_SET_STRIDE;
         assign step = job_done && state == ST_NB && cur_set == s;
         assign nb_act[s] = (rd_ctl[s] != '0);
         assign set_fin[s] = step && rd_left[s] == 16'h0001;
         always_ff @(posedge core_clk)
         begin
            if (srst)
            begin
               rd_ctl[s] <= '0;
               rd_addr[s] <= '0;
               rd_size[s] <= '0;
               rd_left[s] <= '0;
            end
            else
            begin
               if (cfg_ok && cfg_sel == base + SEL_RDADDR0 - SEL_RDCTL0)
               begin
                  rd_addr[s] <= cfg_wdata;
               end
               else if (step)
               begin
                  rd_addr[s] <= rd_addr[s] + WORD_STEP;
               end
               if (cfg_ok && cfg_sel == base + SEL_RDSIZE0 - SEL_RDCTL0)
               begin
                  rd_size[s] <= cfg_wdata[15:0];
               end
               if (cfg_ok && cfg_sel == base)
               begin
                  rd_ctl[s] <= (rd_size[s] == '0) ? '0 : cfg_wdata;
                  rd_left[s] <= rd_size[s];
               end
               else if (step)
               begin
                  rd_left[s] <= rd_left[s] - 16'h0001;
                  if (set_fin[s])
                  begin
                     rd_ctl[s] <= '0;
                  end
               end
            end
         end
      end
   endgenerate

   epb_fifo #(.WIDTH(DW), .DEPTH(NBR_DEPTH)) nbr_i (
      .core_clk(core_clk),
      .srst(srst),
      .in_valid(job_done && state == ST_NB),
      .in_ready(nbr_in_ready),
      .in_data(j_alt ? alt_rdata : din_s3),
      .out_valid(nbr_valid),
      .out_ready(nbr_ready),
      .out_data(nbr_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Transfer engine
   assign launch = (state == ST_IDLE) && (wf_out_valid || rd_pend && !rd_fin || (|nb_act && nbr_in_ready));
   assign din_stable = (din_s2 == din_s3);
   assign gp_done = tick && ph == STROBE_LAST && (j_we || din_stable);
   assign job_done = (state != ST_IDLE) && (j_alt ? alt_done : gp_done);

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         state <= ST_IDLE;
         cur_set <= 1'b0;
         j_alt <= 1'b0;
         j_we <= 1'b0;
         j_addr <= '0;
         ext_data_o <= '0;
         j_rdata <= '0;
      end
      else if (launch)
      begin
         j_alt <= (mode != MODE_GP);
         if (wf_out_valid)
         begin
            state <= ST_WR;
            j_we <= 1'b1;
            j_addr <= wf_out[AW+DW-1:DW];
            ext_data_o <= wf_out[DW-1:0];
         end
         else if (rd_pend)
         begin
            state <= ST_RD;
            j_we <= 1'b0;
            j_addr <= rd_paddr;
         end
         else
         begin
            state <= ST_NB;
            j_we <= 1'b0;
            cur_set <= nb_act[cur_set] ? cur_set : !cur_set;
            j_addr <= remap(rd_addr[nb_act[cur_set] ? cur_set : !cur_set], addrmap);
         end
      end
      else if (job_done)
      begin
         state <= ST_IDLE;
         j_rdata <= j_alt ? alt_rdata : din_s3;
         if (state == ST_NB && set_fin[cur_set])
         begin
            cur_set <= !cur_set;
         end
      end
   end

   assign resp_rdata = j_rdata;
   assign alt_we = j_we;
   assign alt_addr = j_addr;
   assign alt_wdata = ext_data_o;
   assign ext_addr = j_addr;

   always_ff @(posedge core_clk)
   begin
      if (srst || launch || job_done)
      begin
         sdram_req <= !srst && launch && mode == MODE_SDRAM;
         host_req <= !srst && launch && (mode == MODE_HB8 || mode == MODE_HB16);
         ext_wr <= !srst && launch && mode == MODE_GP && wf_out_valid;
         ext_rd <= !srst && launch && mode == MODE_GP && !wf_out_valid;
         ext_data_oe_n <= !(!srst && launch && mode == MODE_GP && wf_out_valid);
      end
   end

   always_ff @(posedge core_clk)
   begin
      din_s1 <= ext_data_i;
      din_s2 <= din_s1;
      din_s3 <= din_s2;
   end

   ////////////////////////////////////////////////////////////////////////////
   // General-purpose link clock and frame
   assign tick = (baud_cnt == '0);

   always_ff @(posedge core_clk)
   begin
      if (srst || tick)
      begin
         baud_cnt <= srst ? BAUD_RST : baud;
      end
      else
      begin
         baud_cnt <= baud_cnt - 16'h0001;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         ext_clk <= 1'b0;
      end
      else if (tick && (!gpcfg[GP_CLK_GATED] || ext_rd || ext_wr || ext_clk))
      begin
         ext_clk <= !ext_clk;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst || launch)
      begin
         ph <= '0;
      end
      else if (tick && ph != STROBE_LAST)
      begin
         ph <= ph + 2'h1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         ext_frame <= 1'b0;
         frame_cnt <= '0;
      end
      else if (launch && mode == MODE_GP && gpcfg[GP_FRAME_EN] && frame_cnt == '0)
      begin
         ext_frame <= 1'b1;
         frame_cnt <= gpcfg[4:0];
      end
      else if (gpcfg[GP_CLK_GATED] && state == ST_IDLE && !launch && !ext_clk && frame_cnt != '0)
      begin
         // Stopped gated clock would let the count drop on every tick
         ext_frame <= 1'b0;
         frame_cnt <= '0;
      end
      else if (tick && !ext_clk && frame_cnt != '0)
      begin
         frame_cnt <= frame_cnt - 5'h01;
         ext_frame <= (frame_cnt != FRAME_MIN);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt registers
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         done_stk <= '0;
      end
      else
      begin
         done_stk <= set_fin | (done_stk & ~(cfg_ok && cfg_sel == SEL_ICLR ? cfg_wdata[1:0] : 2'b00));
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         irq_raw <= '0;
         irq_masked <= '0;
         irq_m_cpu <= 1'b0;
         irq_c_cpu <= 1'b0;
         dma_req_ch20 <= 1'b0;
         dma_req_ch22 <= 1'b0;
      end
      else
      begin
         irq_raw <= {wf_in_ready, nbr_valid, done_stk};
         irq_masked <= irq_raw & imask;
         irq_m_cpu <= |irq_masked;
         irq_c_cpu <= |irq_masked;
         dma_req_ch20 <= irq_masked[IRQ_NBR] | (|irq_masked[1:0]);
         dma_req_ch22 <= irq_masked[IRQ_WSPACE];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   wfifo_stall_a: assert property (pick_m && m_we && own_ok && !wf_in_ready |-> !m_ready)
      else $error("write taken while buffer full");
   wr_first_a: assert property (state == ST_IDLE && wf_out_valid |=> state == ST_WR)
      else $error("queued write not issued first");
   blk_read_a: assert property (rd_pend && !rd_fin && !rd_owner_c && m_req && !m_we |-> !m_ready)
      else $error("blocking read released early");
   nb_start_a: assert property (cfg_ok && cfg_sel == SEL_RDCTL0 && cfg_wdata != '0 && rd_size[0] != '0 |=> nb_act[0])
      else $error("background read not started");
   nbr_irq_a: assert property (nbr_valid ##1 nbr_valid |=> irq_raw[IRQ_NBR])
      else $error("buffer data without interrupt");
   route_alt_a: assert property (sdram_req |-> !ext_rd && !ext_wr && mode == MODE_SDRAM)
      else $error("sdram transfer on general pins");
   gp_mode_a: assert property ($rose(ext_wr) || $rose(ext_rd) |-> $past(mode) == MODE_GP)
      else $error("general strobe outside mode 0");
   win_stall_a: assert property (win_active |-> !pick_m)
      else $error("master not stalled in window");
   cs_block_a: assert property (take && pick_m && !own_ok |=> m_err && !rd_pend)
      else $error("foreign chip-select not blocked");
   cfg_prot_a: assert property (cfg_wr && cfg_from_ctl && cfg_sel == SEL_CFG |=> $stable(mode))
      else $error("control changed configuration");
   bridge_a: assert property (c_ready && !rd_fin |-> c_slot && !rev0)
      else $error("control transfer off bridge slot");
   frame_len_a: assert property (frame_cnt <= FRAME_MAX)
      else $error("frame longer than limit");
   gated_clk_a: assert property (gpcfg[GP_CLK_GATED] && !ext_rd && !ext_wr && !ext_clk |=> !ext_clk)
      else $error("gated clock runs while idle");

   wr_seen_c: cover property (ext_wr ##[1:40] !ext_wr);
   rd_seen_c: cover property (rd_fin && !rd_owner_c);
   nb_done_c: cover property (set_fin[0] ##[1:200] set_fin[1]);
   win_seen_c: cover property (win_active && m_req);
endmodule : epb_core

// ### verif/epb_far_model.sv
`timescale 1ns/100ps
module epb_far_model
   (
   input wire logic core_clk,
   input wire logic ext_rd,
   input wire logic [31:0] ext_addr,
   output logic [31:0] ext_data_i,
   input wire logic sdram_req,
   input wire logic host_req,
   input wire logic [31:0] alt_addr,
   output logic alt_done,
   output logic [31:0] alt_rdata
   );
   logic [31:0] last = 32'h0;
   logic [1:0] cnt = 2'h0;
   initial alt_done = 1'b0;
   ////////////////////////////////////////
   // Pin data live only under the read strobe
   assign ext_data_i = ext_rd ? (ext_addr ^ 32'h5a5a_0000) : ~last;
   always @(posedge core_clk)
   begin
      if (ext_rd)
         last <= ext_addr ^ 32'h5a5a_0000;
   end
   ////////////////////////////////////////
   // Engine answers a few cycles late
   assign alt_rdata = alt_done ? ~alt_addr : last;
   always @(posedge core_clk)
   begin
      alt_done <= 1'b0;
      if ((sdram_req || host_req) && !alt_done)
      begin
         cnt <= cnt + 2'h1;
         if (cnt == 2'h3)
            alt_done <= 1'b1;
      end
   end
endmodule : epb_far_model

// ### verif/external_parallel_bus_interface_tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module external_parallel_bus_interface_tb;
   import epb_pkg::*;
   logic core_clk = 0, srst = 1, strap_rev0 = 0, ctl_bridge_quarter = 0, m_req = 0, m_we = 0, c_req = 0, c_we = 0;
   logic cfg_wr = 0, cfg_from_ctl = 0, nbr_ready = 0, alt_done, m_ready, m_err, c_ready, c_err, er;
   logic [31:0] m_addr = '0, m_wdata = '0, c_addr = '0, c_wdata = '0, cfg_wdata = '0, ext_data_i, alt_rdata, rd;
   logic [3:0] cfg_sel = '0, irq_raw, irq_masked;
   logic irq_m_cpu, irq_c_cpu, dma_req_ch20, dma_req_ch22, nbr_valid, ext_clk, ext_frame, ext_rd, ext_wr;
   logic ext_data_oe_n, sdram_req, host_req, alt_we;
   logic [31:0] resp_rdata, nbr_data, ext_addr, ext_data_o, alt_addr, alt_wdata;
   int n_errors = 0, samples_checked = 0;
   epb_core u_dut (.core_clk, .srst, .strap_rev0, .ctl_bridge_quarter, .m_req, .m_we, .m_addr, .m_wdata, .m_ready,
      .m_err, .c_req, .c_we, .c_addr, .c_wdata, .c_ready, .c_err, .resp_rdata, .cfg_wr, .cfg_from_ctl, .cfg_sel,
      .cfg_wdata, .irq_raw, .irq_masked, .irq_m_cpu, .irq_c_cpu, .dma_req_ch20, .dma_req_ch22, .nbr_valid,
      .nbr_ready, .nbr_data, .ext_clk, .ext_frame, .ext_rd, .ext_wr, .ext_addr, .ext_data_o, .ext_data_oe_n,
      .ext_data_i, .sdram_req, .host_req, .alt_we, .alt_addr, .alt_wdata, .alt_done, .alt_rdata);
   epb_far_model u_far (.core_clk, .ext_rd, .ext_addr, .ext_data_i, .sdram_req, .host_req, .alt_addr, .alt_done,
      .alt_rdata);
   initial
   begin
      forever #2.5 core_clk = ~core_clk;
   end
   ////////////////////////////////////////
   task automatic req(input logic ctl, we, input logic [31:0] a, d, output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge core_clk);
      #1;
      if (ctl) {c_req, c_we, c_addr, c_wdata} = {1'b1, we, a, d};
      else {m_req, m_we, m_addr, m_wdata} = {1'b1, we, a, d};
      do
      begin
         @(negedge core_clk);
         n++;
      end
      while ((ctl ? c_ready : m_ready) !== 1'b1 && n < 5000);
      q = resp_rdata;
      @(posedge core_clk);
      #1;
      c_req = 0;
      m_req = 0;
      e = ctl ? c_err : m_err;
      @(posedge core_clk);
      if (n >= 5000) n_errors++;
   endtask : req
   task automatic cfg(input logic ctl, input logic [3:0] s, input logic [31:0] d);
      @(posedge core_clk);
      #1;
      {cfg_wr, cfg_from_ctl, cfg_sel, cfg_wdata} = {1'b1, ctl, s, d};
      @(posedge core_clk);
      #1;
      cfg_wr = 0;
   endtask : cfg
   task automatic wait_for(ref logic s, input logic v);
      int n;
      n = 0;
      while (s !== v && n < 5000)
      begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n >= 5000) n_errors++;
   endtask : wait_for
   task automatic ext_write(input logic [31:0] a, d);
      wait_for(ext_wr, 1'b1);
      `CHK(ext_addr, a)
      `CHK(ext_data_o, d)
      `CHK(ext_data_oe_n, 1'b0)
      wait_for(ext_wr, 1'b0);
   endtask : ext_write
   ////////////////////////////////////////
   task automatic t_write;
      logic [31:0] q;
      logic e;
      cfg(1'b1, SEL_CFG, 32'h1);
      fork
         for (int i = 0; i < 12; i++)
         begin
            req(1'b0, 1'b1, 32'h10 + 4 * i, 32'h1111_0000 + i, q, e);
            `CHK(e, 1'b0)
         end
         for (int i = 0; i < 12; i++) ext_write(32'h10 + 4 * i, 32'h1111_0000 + i);
      join
      cfg(1'b0, SEL_ADDRMAP, 32'h7);
      fork
         req(1'b0, 1'b1, 32'h8000_0040, 32'h2, q, e);
         ext_write(32'h3000_0040, 32'h2);
      join
      cfg(1'b0, SEL_ADDRMAP, 32'h0);
      cfg(1'b0, SEL_GPCFG, 32'h63);
      repeat (8) @(posedge core_clk);
      #1;
      `CHK(ext_clk, 1'b0)
      fork
         req(1'b0, 1'b1, 32'h60, 32'h3, q, e);
         begin
            wait_for(ext_wr, 1'b1);
            `CHK(ext_frame, 1'b1)
            wait_for(ext_frame, 1'b0);
            `CHK({ext_frame, ext_clk}, 2'b00)
         end
      join
      cfg(1'b0, SEL_GPCFG, 32'h01);
      $display("test write done");
   endtask : t_write
   task automatic t_read;
      time t0;
      req(1'b0, 1'b0, 32'h300, 32'h0, rd, er);
      `CHK(rd, 32'h5a5a_0300)
      cfg(1'b1, SEL_RTWIN, 32'h0000_ff01);
      ctl_bridge_quarter = 1;
      req(1'b1, 1'b0, 32'h304, 32'h0, rd, er);
      `CHK(rd, 32'h5a5a_0304)
      t0 = $time;
      req(1'b0, 1'b1, 32'h500, 32'h6, rd, er);
      `CHK(($time - t0) >= 1000, 1'b1)
      cfg(1'b1, SEL_RTWIN, 32'h0);
      $display("test read done");
   endtask : t_read
   task automatic t_cs;
      cfg(1'b0, SEL_CSPROT, 32'hfb);
      req(1'b0, 1'b1, 32'h1000_0000, 32'h5, rd, er);
      `CHK(er, 1'b1)
      cfg(1'b1, SEL_CSPROT, 32'hff);
      req(1'b0, 1'b0, 32'h1000_0000, 32'h0, rd, er);
      `CHK(er, 1'b1)
      cfg(1'b0, SEL_CSPROT, 32'hff);
      $display("test protect done");
   endtask : t_cs
   task automatic t_mode;
      for (int m = 1; m < 4; m++)
      begin
         cfg(1'b0, SEL_CFG, m);
         fork
            req(1'b0, 1'b1, 32'h40, 32'h9, rd, er);
            if (m == 1) wait_for(sdram_req, 1'b1);
            else wait_for(host_req, 1'b1);
         join
         `CHK({sdram_req, host_req}, (m == 1) ? 2'b10 : 2'b01)
         `CHK(alt_addr, 32'h40)
         wait_for(alt_done, 1'b1);
      end
      cfg(1'b0, SEL_CFG, 32'h0);
      $display("test mode done");
   endtask : t_mode
   task automatic t_bg;
      for (int s = 0; s < 2; s++)
      begin
         cfg(1'b0, SEL_RDSIZE0 + s * SEL_SET_STRIDE, 32'h2);
         cfg(1'b0, SEL_RDADDR0 + s * SEL_SET_STRIDE, 32'h200 + 32'h200 * s);
         cfg(1'b0, SEL_RDCTL0 + s * SEL_SET_STRIDE, 32'h1);
      end
      for (int i = 0; i < 4; i++)
      begin
         wait_for(nbr_valid, 1'b1);
         `CHK(nbr_data, 32'h5a5a_0200 + 32'h200 * (i / 2) + 4 * (i % 2))
         nbr_ready = 1;
         @(posedge core_clk);
         #1;
         nbr_ready = 0;
      end
      `CHK(irq_raw[IRQ_DONE0], 1'b1)
      cfg(1'b0, SEL_IMASK, 32'h1);
      repeat (3) @(posedge core_clk);
      #1;
      `CHK({irq_masked, irq_m_cpu, irq_c_cpu, dma_req_ch20, dma_req_ch22}, 8'h1e)
      cfg(1'b0, SEL_ICLR, 32'h3);
      cfg(1'b0, SEL_IMASK, 32'h8);
      repeat (3) @(posedge core_clk);
      #1;
      `CHK({irq_raw, irq_masked, dma_req_ch20, dma_req_ch22}, 10'h221)
      $display("test background done");
   endtask : t_bg
   task automatic conclude;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : conclude
   ////////////////////////////////////////
   initial
   begin
      #400000;
      n_errors++;
      conclude();
   end
   initial
   begin
      repeat (5) @(posedge core_clk);
      #1;
      srst = 0;
      `CHK({ext_data_oe_n, ext_frame, nbr_valid, irq_raw}, 7'h40)
      t_write();
      t_read();
      t_cs();
      t_mode();
      t_bg();
      conclude();
   end
endmodule : external_parallel_bus_interface_tb
